//--- rtl/thresh_mon_cfg.svh
// constants of the threshold monitor: offsets, fields, reset values, hysteresis
`ifndef THRESH_MON_CFG_SVH
`define THRESH_MON_CFG_SVH

`define CMD_CLEAR_FAULTS 8'h03
`define CMD_OVERTEMP_FAULT_LIMIT_LIM   8'h4f
`define CMD_OVERTEMP_WARNING_LIMIT_LIM  8'h51
`define CMD_PG_LIM       8'h5f
`define CMD_OP_WARN_LIM  8'h6b
`define CMD_STATUS_BYTE  8'h78
`define CMD_STATUS_WORD  8'h79
`define CMD_STATUS_OUT   8'h7a
`define CMD_STATUS_INPUT 8'h7c
`define CMD_STATUS_TEMP  8'h7d
`define CMD_STATUS_V2    8'hf2

`define RST_OVERTEMP_FAULT_LIMIT_LIM   8'h85
`define RST_OVERTEMP_WARNING_LIMIT_LIM  8'h7e
`define RST_PG_LIM       8'h8d
`define RST_OP_WARN_LIM  8'hff

`define SB_OFF      6
`define SB_TEMP     2
`define SB_UNK      0
`define SW_VOUT     7
`define SW_INPUT    5
`define SW_PGB      3
`define SW_UNK      0
`define SO_UV_WARN  5
`define ST_OTF      7
`define ST_OTW      6
`define SI_OPW      0
`define SV2_PGB     0

`define LOG_PTR_LAST 3'h6

`define PG_HYST_MV     250
`define VOUT_FS_MV     19420
`define VOUT_FS_CODE   255
`define PG_HYST_CODE   ((`PG_HYST_MV * `VOUT_FS_CODE + `VOUT_FS_MV - 1) / `VOUT_FS_MV)

`endif

//--- rtl/thresh_mon_pkg.sv
// types shared by the threshold monitor and its bench
package thresh_mon_pkg;

  typedef enum logic [0:0] {
    PG_LOW  = 1'b0,
    PG_HIGH = 1'b1
  } pg_state_e;

  typedef enum logic [1:0] {
    EV_NONE       = 2'b00,
    EV_OVERTEMP_WARNING_LIMIT    = 2'b01,
    EV_OVERPOWER_WARNING_BIT = 2'b10
  } log_id_e;

  typedef struct packed {
    logic [7:0] vout;
    logic [7:0] temp;
    logic [7:0] pin;
  } telem_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } cmd_s;

  typedef struct packed {
    logic pg_pin_en;
    logic fault_pin_en;
    logic alert_pin_en;
    logic mask_pgb;
    logic mask_temp;
    logic mask_input;
    logic temp_fault_mask;
  } cfg_s;

  typedef struct packed {
    logic [7:0]  status_byte;
    logic [7:0]  status_hi;
    logic [7:0]  status_out;
    logic [7:0]  status_input;
    logic [7:0]  status_temp;
    logic [7:0]  status_v2;
  } status_s;

  typedef struct packed {
    logic        wr;
    log_id_e     id;
    logic [2:0]  addr;
    logic [15:0] stamp;
  } log_s;

endpackage

//--- rtl/threshold_monitor_status.sv
// threshold compare, status flags, pins and event log for four host limits
`include "thresh_mon_cfg.svh"

module threshold_monitor_status (
  input  wire logic                   I_CLK,
  input  wire logic                   I_RST_N,
  input  wire thresh_mon_pkg::cmd_s   I_CMD,
  input  wire thresh_mon_pkg::telem_s I_TELEM,
  input  wire thresh_mon_pkg::cfg_s   I_CFG,
  input  wire logic                   I_RUN,
  input  wire logic                   I_SWITCH_EN,
  input  wire logic                   I_OTHER_FAULT,
  input  wire logic                   I_LOG_AVAIL,
  output logic                        O_RD_VALID,
  output logic [15:0]                 O_RD_DATA,
  output thresh_mon_pkg::status_s     O_STATUS,
  output logic                        O_POWER_GOOD,
  output logic                        O_FAULT,
  output logic                        O_ALERT_N,
  output logic                        O_SWITCH_OFF,
  output thresh_mon_pkg::log_s        O_LOG,
  output logic [2:0]                  O_LOG_PTR
);

  typedef struct packed {
    thresh_mon_pkg::pg_state_e pg_st;
    logic [7:0]                lim_otf;
    logic [7:0]                lim_otw;
    logic [7:0]                lim_pg;
    logic [7:0]                lim_op;
    logic                      f_pgb;
    logic                      f_otw;
    logic                      f_otf;
    logic                      f_op;
    logic                      sw_off;
    logic                      otw_prev;
    logic                      op_prev;
    logic                      op_pend;
    logic [2:0]                log_ptr;
    logic [15:0]               stamp;
    thresh_mon_pkg::log_s      log;
    thresh_mon_pkg::status_s   status;
    logic                      pg_pin;
    logic                      fault_pin;
    logic                      alert_n;
    logic                      rd_valid;
    logic [15:0]               rd_data;
  } state_s;

  localparam logic [8:0] PG_HYST = 9'(`PG_HYST_CODE);

  state_s st_r;
  state_s st_nxt;

  logic       otw_c;
  logic       otf_c;
  logic       op_c;
  logic       pgl_c;
  logic       fault_c;
  logic       pgb_set;
  logic       clr;
  logic       ev_otw;
  logic       ev_op;
  logic       log_op;
  logic [8:0] pg_rise;

  // ----------------------------------------------------------------
  // comparisons
  // ----------------------------------------------------------------
  always_comb begin
    otw_c   = I_TELEM.temp > st_r.lim_otw;
    otf_c   = I_TELEM.temp > st_r.lim_otf;
    op_c    = I_TELEM.pin > st_r.lim_op;
    pgl_c   = I_TELEM.vout < st_r.lim_pg;
    // short-circuit is handled elsewhere and never enters here
    fault_c = otf_c | st_r.sw_off | I_OTHER_FAULT;
    pgb_set = (I_RUN & pgl_c) | fault_c;
    pg_rise = {1'b0, st_r.lim_pg} + PG_HYST;
    clr     = I_CMD.valid & I_CMD.write & (I_CMD.code == `CMD_CLEAR_FAULTS);
    ev_otw  = otw_c & ~st_r.otw_prev;
    ev_op   = op_c & ~st_r.op_prev;
    // an overpower event colliding with a temperature event waits a cycle
    log_op  = (ev_op | st_r.op_pend) & ~ev_otw;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // host word writes; upper byte of each limit is read-only zero
    if (I_CMD.valid && I_CMD.write) begin
      unique case (I_CMD.code)
        `CMD_OVERTEMP_FAULT_LIMIT_LIM:  st_nxt.lim_otf = I_CMD.data[7:0];
        `CMD_OVERTEMP_WARNING_LIMIT_LIM: st_nxt.lim_otw = I_CMD.data[7:0];
        `CMD_PG_LIM:      st_nxt.lim_pg  = I_CMD.data[7:0];
        `CMD_OP_WARN_LIM: st_nxt.lim_op  = I_CMD.data[7:0];
        default: ;
      endcase
    end

    // host word reads, answered one cycle later; unknown codes read zero
    st_nxt.rd_valid = I_CMD.valid & ~I_CMD.write;
    st_nxt.rd_data  = 16'h0000;
    if (I_CMD.valid && !I_CMD.write) begin
      unique case (I_CMD.code)
        `CMD_OVERTEMP_FAULT_LIMIT_LIM:   st_nxt.rd_data = {8'h00, st_r.lim_otf};
        `CMD_OVERTEMP_WARNING_LIMIT_LIM:  st_nxt.rd_data = {8'h00, st_r.lim_otw};
        `CMD_PG_LIM:       st_nxt.rd_data = {8'h00, st_r.lim_pg};
        `CMD_OP_WARN_LIM:  st_nxt.rd_data = {8'h00, st_r.lim_op};
        `CMD_STATUS_BYTE:  st_nxt.rd_data = {8'h00, st_r.status.status_byte};
        `CMD_STATUS_WORD:  st_nxt.rd_data = {st_r.status.status_hi,
                                             st_r.status.status_byte};
        `CMD_STATUS_OUT:   st_nxt.rd_data = {8'h00, st_r.status.status_out};
        `CMD_STATUS_INPUT: st_nxt.rd_data = {8'h00, st_r.status.status_input};
        `CMD_STATUS_TEMP:  st_nxt.rd_data = {8'h00, st_r.status.status_temp};
        `CMD_STATUS_V2:    st_nxt.rd_data = {8'h00, st_r.status.status_v2};
        default:           st_nxt.rd_data = 16'h0000;
      endcase
    end

    // switch held off while the temperature stays above the fault limit
    st_nxt.sw_off = otf_c;

    // power-good state
    unique case (st_r.pg_st)
      thresh_mon_pkg::PG_HIGH: begin
        if (pgb_set) begin
          st_nxt.pg_st = thresh_mon_pkg::PG_LOW;
        end
      end
      thresh_mon_pkg::PG_LOW: begin
        if (!fault_c && I_SWITCH_EN && ({1'b0, I_TELEM.vout} > pg_rise)) begin
          st_nxt.pg_st = thresh_mon_pkg::PG_HIGH;
        end
      end
    endcase

    // sticky flags: a live condition always wins over clear-faults
    st_nxt.f_pgb = pgb_set | (st_r.f_pgb & ~clr);
    st_nxt.f_otw = otw_c | (st_r.f_otw & ~clr);
    st_nxt.f_op  = op_c | (st_r.f_op & ~clr);
    st_nxt.f_otf = otf_c | (st_r.f_otf & ~(clr & ~st_r.sw_off));

    // status registers follow the flags
    st_nxt.status = '0;
    st_nxt.status.status_byte[`SB_UNK]  = st_nxt.f_pgb | st_nxt.f_op
                                        | st_nxt.f_otf;
    st_nxt.status.status_byte[`SB_TEMP] = st_nxt.f_otw | st_nxt.f_otf;
    st_nxt.status.status_byte[`SB_OFF]  = st_nxt.f_otf;
    st_nxt.status.status_hi[`SW_PGB]    = st_nxt.f_pgb;
    st_nxt.status.status_hi[`SW_UNK]    = st_nxt.f_pgb | st_nxt.f_op;
    st_nxt.status.status_hi[`SW_INPUT]  = st_nxt.f_op;
    st_nxt.status.status_hi[`SW_VOUT]   = st_nxt.f_otf;
    st_nxt.status.status_out[`SO_UV_WARN] = st_nxt.f_otf;
    st_nxt.status.status_temp[`ST_OTW]  = st_nxt.f_otw;
    st_nxt.status.status_temp[`ST_OTF]  = st_nxt.f_otf;
    st_nxt.status.status_input[`SI_OPW] = st_nxt.f_op;
    st_nxt.status.status_v2[`SV2_PGB]   = st_nxt.f_pgb;

    // pins; an unconfigured pin rests inactive
    st_nxt.pg_pin    = I_CFG.pg_pin_en
                     & (st_nxt.pg_st == thresh_mon_pkg::PG_HIGH);
    st_nxt.fault_pin = I_CFG.fault_pin_en & I_CFG.temp_fault_mask
                     & st_nxt.f_otf;
    // mask bit high blocks its category from the alert line
    st_nxt.alert_n   = ~(I_CFG.alert_pin_en
                     & ((st_nxt.f_pgb & ~I_CFG.mask_pgb)
                      | ((st_nxt.f_otw | st_nxt.f_otf) & ~I_CFG.mask_temp)
                      | (st_nxt.f_op & ~I_CFG.mask_input)));

    // event log; an entry that finds no free slot is dropped, not retried
    st_nxt.stamp    = st_r.stamp + 16'h0001;
    st_nxt.otw_prev = otw_c;
    st_nxt.op_prev  = op_c;
    st_nxt.op_pend  = (ev_op | st_r.op_pend) & ev_otw;
    st_nxt.log.wr   = 1'b0;
    if ((ev_otw || log_op) && I_LOG_AVAIL) begin
      st_nxt.log.wr    = 1'b1;
      st_nxt.log.id    = ev_otw ? thresh_mon_pkg::EV_OVERTEMP_WARNING_LIMIT
                                : thresh_mon_pkg::EV_OVERPOWER_WARNING_BIT;
      st_nxt.log.addr  = st_r.log_ptr;
      st_nxt.log.stamp = st_r.stamp;
      st_nxt.log_ptr   = (st_r.log_ptr < `LOG_PTR_LAST)
                       ? st_r.log_ptr + 3'h1 : 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st_r          <= '0;
      st_r.pg_st    <= thresh_mon_pkg::PG_LOW;
      st_r.lim_otf  <= `RST_OVERTEMP_FAULT_LIMIT_LIM;
      st_r.lim_otw  <= `RST_OVERTEMP_WARNING_LIMIT_LIM;
      st_r.lim_pg   <= `RST_PG_LIM;
      st_r.lim_op   <= `RST_OP_WARN_LIM;
      st_r.log.id   <= thresh_mon_pkg::EV_NONE;
      st_r.alert_n  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_RD_VALID   = st_r.rd_valid;
  assign O_RD_DATA    = st_r.rd_data;
  assign O_STATUS     = st_r.status;
  assign O_POWER_GOOD = st_r.pg_pin;
  assign O_FAULT      = st_r.fault_pin;
  assign O_ALERT_N    = st_r.alert_n;
  assign O_SWITCH_OFF = st_r.sw_off;
  assign O_LOG        = st_r.log;
  assign O_LOG_PTR    = st_r.log_ptr;

endmodule // threshold_monitor_status

//--- verification/testbench.sv
// self-checking bench of the threshold monitor
`include "thresh_mon_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk, rst_n, run, sw_en, oth_flt, log_av, rd_v, pg, fault_output_pin, alert_n, sw_off;
  thresh_mon_pkg::cmd_s    cmd;
  thresh_mon_pkg::telem_s  telem;
  thresh_mon_pkg::cfg_s    cfg;
  thresh_mon_pkg::status_s st;
  thresh_mon_pkg::log_s    lg, last_lg;
  logic [15:0]             rd_d;
  logic [2:0]              ptr;
  int                      n_errors = 0, samples_checked = 0, cycles = 0;

  thresh_host host_u (.i_clk(clk), .o_cmd(cmd));
  threshold_monitor_status dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_CMD(cmd), .I_TELEM(telem),
    .I_CFG(cfg), .I_RUN(run), .I_SWITCH_EN(sw_en), .I_OTHER_FAULT(oth_flt),
    .I_LOG_AVAIL(log_av), .O_RD_VALID(rd_v), .O_RD_DATA(rd_d), .O_STATUS(st),
    .O_POWER_GOOD(pg), .O_FAULT(fault_output_pin), .O_ALERT_N(alert_n), .O_SWITCH_OFF(sw_off),
    .O_LOG(lg), .O_LOG_PTR(ptr));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // log capture and hang guard; the whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (lg.wr === 1'b1) last_lg <= lg;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end

  // ----
  // helpers
  // ----
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host_u.xfer(1'b1, c, d);
    #1;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    host_u.xfer(1'b0, c, 16'h0000);
    #1;
    check("read", {rd_v, rd_d[14:0]}, {1'b1, exp[14:0]});
    check("read top", 16'(rd_d[15]), 16'(exp[15]));
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_limits();
    logic [7:0] codes [4] = '{8'h4f, 8'h51, 8'h5f, 8'h6b};
    logic [7:0] rst_v [4] = '{8'h85, 8'h7e, 8'h8d, 8'hff};
    for (int i = 0; i < 4; i++) rd(codes[i], {8'h00, rst_v[i]});
    for (int i = 0; i < 4; i++) begin
      wr(codes[i], {8'ha5, 8'hf0 + 8'(i)});
      rd(codes[i], {8'h00, 8'hf0 + 8'(i)});
      wr(codes[i], {8'h00, rst_v[i]});
    end
    rd(8'h22, 16'h0000);
    rd(`CMD_STATUS_WORD, 16'h0000);
  endtask

  task automatic t_temp_warn();
    @(posedge clk) telem.temp <= 8'h7f;
    step(2);
    check("temp warn", 16'({st.status_temp[`ST_OTW], st.status_byte[`SB_TEMP], alert_n, sw_off,
      ptr}), 16'(7'b1100_001));
    check("log entry", 16'({last_lg.id, last_lg.addr}), 16'(5'b01_000));
    wr(`CMD_CLEAR_FAULTS, 16'h0000);
    check("warn kept", 16'(st.status_temp[`ST_OTW]), 16'h1);
    @(posedge clk) telem.temp <= 8'h7e;
    step(2);
    check("warn latched", 16'(st.status_temp[`ST_OTW]), 16'h1);
    wr(`CMD_CLEAR_FAULTS, 16'h0000);
    check("warn cleared", 16'({st.status_temp[`ST_OTW], alert_n}), 16'h1);
  endtask

  task automatic t_log();
    logic [15:0] prev_stamp;
    prev_stamp = 16'h0000;
    for (int i = 2; i < 10; i++) begin
      @(posedge clk) {log_av, telem.temp} <= {(i != 9), 8'h7f};
      step(2);
      // each pass of this loop lasts seven cycles
      if (i > 2 && i < 9) check("log stamp", last_lg.stamp - prev_stamp, 16'h0007);
      prev_stamp = last_lg.stamp;
      @(posedge clk) telem.temp <= 8'h00;
      wr(`CMD_CLEAR_FAULTS, 16'h0000);
      check("log pointer", 16'(ptr), 16'((i == 9) ? 1 : i % 7));
    end
    @(posedge clk) log_av <= 1'b1;
  endtask

  task automatic t_power();
    @(posedge clk) {run, telem.vout} <= {1'b1, 8'h92};
    step(3);
    check("pg up", 16'(pg), 16'h1);
    @(posedge clk) telem.vout <= 8'h8c;
    step(2);
    check("pg low", 16'({pg, st.status_hi[`SW_PGB], st.status_hi[`SW_UNK], st.status_byte[`SB_UNK],
      st.status_v2[`SV2_PGB], alert_n}), 16'(6'b011111));
    @(posedge clk) telem.vout <= 8'h91;
    step(2);
    check("pg hyst", 16'(pg), 16'h0);
    @(posedge clk) {sw_en, telem.vout} <= {1'b0, 8'h92};
    step(2);
    check("pg no switch", 16'(pg), 16'h0);
    @(posedge clk) sw_en <= 1'b1;
    step(2);
    check("pg latched", 16'({pg, st.status_v2[`SV2_PGB]}), 16'h3);
    wr(`CMD_CLEAR_FAULTS, 16'h0000);
    check("pg cleared", 16'(st.status_v2[`SV2_PGB]), 16'h0);
    @(posedge clk) telem.temp <= 8'h90;
    step(2);
    check("ot fault", 16'({sw_off, fault_output_pin, pg, st.status_byte[`SB_OFF], st.status_byte[`SB_TEMP],
      st.status_hi[`SW_VOUT], st.status_hi[`SW_PGB], st.status_out[`SO_UV_WARN],
      st.status_temp[`ST_OTF], st.status_v2[`SV2_PGB], alert_n}),
      16'(11'b110_1111_1110));
    rd(`CMD_STATUS_WORD, 16'h8945);
    rd(`CMD_STATUS_TEMP, 16'h00c0);
    rd(`CMD_STATUS_OUT, 16'h0020);
    rd(`CMD_STATUS_V2, 16'h0001);
    wr(`CMD_CLEAR_FAULTS, 16'h0000);
    check("fault kept", 16'(st.status_temp[`ST_OTF]), 16'h1);
    @(posedge clk) telem.temp <= 8'h00;
    step(2);
    wr(`CMD_CLEAR_FAULTS, 16'h0000);
    step(1);
    check("fault cleared", 16'({st.status_temp[`ST_OTF], sw_off, pg}), 16'h1);
    @(posedge clk) oth_flt <= 1'b1;
    step(2);
    check("other fault", 16'(pg), 16'h0);
    @(posedge clk) oth_flt <= 1'b0;
  endtask

  task automatic t_input();
    wr(`CMD_CLEAR_FAULTS, 16'h0000);
    check("pgb cleared", 16'({pg, st.status_hi[`SW_UNK], st.status_byte[`SB_UNK],
      st.status_v2[`SV2_PGB]}), 16'h8);
    wr(`CMD_OP_WARN_LIM, 16'h0040);
    @(posedge clk) telem.pin <= 8'h41;
    step(2);
    check("op warn", 16'({st.status_input[`SI_OPW], st.status_hi[`SW_INPUT],
      st.status_hi[`SW_UNK], st.status_byte[`SB_UNK], alert_n, last_lg.id}),
      16'(7'b11110_10));
    rd(`CMD_STATUS_INPUT, 16'h0001);
    @(posedge clk) telem.pin <= 8'h40;
    wr(`CMD_CLEAR_FAULTS, 16'h0000);
    check("op cleared", 16'({st.status_input[`SI_OPW], alert_n}), 16'h1);
    @(posedge clk) {cfg.alert_pin_en, telem.pin} <= {1'b0, 8'h41};
    step(3);
    check("alert off", 16'({st.status_input[`SI_OPW], alert_n}), 16'h3);
  endtask

  task automatic final_report();
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    {rst_n, run, oth_flt, sw_en, log_av} = 5'b00011;
    telem = '0;
    cfg = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_limits();
    t_temp_warn();
    t_log();
    t_power();
    t_input();
    final_report();
  end
endmodule // testbench

//--- verification/thresh_host.sv
// behavioural host controller issuing word commands to the monitor
module thresh_host (
  input  wire logic            i_clk,
  output thresh_mon_pkg::cmd_s o_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // unlock code value is arbitrary; the monitor ignores it
  localparam logic [7:0] UNLOCK_CODE = 8'hfa;

  initial o_cmd = '0;

  // released fields show inverted values so a stale sample cannot look valid
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    if (w) begin
      @(posedge i_clk) o_cmd <= '{1'b1, 1'b1, UNLOCK_CODE, 16'h0000};
    end
    @(posedge i_clk) o_cmd <= '{1'b1, w, c, d};
    @(posedge i_clk) o_cmd <= '{1'b0, ~w, ~c, ~d};
  endtask
endmodule // thresh_host

//--- verification/thresh_mon_monitor.sv
// port assertions of the threshold monitor
`include "thresh_mon_cfg.svh"
module thresh_mon_monitor (
  input wire logic                    I_CLK,
  input wire logic                    I_RST_N,
  input wire thresh_mon_pkg::cmd_s    I_CMD,
  input wire thresh_mon_pkg::telem_s  I_TELEM,
  input wire thresh_mon_pkg::cfg_s    I_CFG,
  input wire logic                    I_RUN,
  input wire logic                    I_OTHER_FAULT,
  input wire logic                    O_RD_VALID,
  input wire thresh_mon_pkg::status_s O_STATUS,
  input wire logic                    O_POWER_GOOD,
  input wire logic                    O_FAULT,
  input wire logic                    O_ALERT_N,
  input wire logic                    O_SWITCH_OFF,
  input wire thresh_mon_pkg::log_s    O_LOG,
  input wire logic [2:0]              O_LOG_PTR
);
  logic [7:0] otf_r, otw_r, pgl_r;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  // shadow limits follow host writes so compares use the live values
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      otf_r <= `RST_OVERTEMP_FAULT_LIMIT_LIM;
      otw_r <= `RST_OVERTEMP_WARNING_LIMIT_LIM;
      pgl_r <= `RST_PG_LIM;
    end else if (I_CMD.valid && I_CMD.write) begin
      if (I_CMD.code == `CMD_OVERTEMP_FAULT_LIMIT_LIM) otf_r <= I_CMD.data[7:0];
      if (I_CMD.code == `CMD_OVERTEMP_WARNING_LIMIT_LIM) otw_r <= I_CMD.data[7:0];
      if (I_CMD.code == `CMD_PG_LIM) pgl_r <= I_CMD.data[7:0];
    end
  end

  sequence ot_fault_seen;
    I_TELEM.temp > otf_r;
  endsequence
  sequence ot_fault_shown;
    O_SWITCH_OFF && O_STATUS.status_byte[`SB_OFF] && O_STATUS.status_hi[`SW_VOUT] &&
    O_STATUS.status_out[`SO_UV_WARN] && O_STATUS.status_temp[`ST_OTF] && O_STATUS.status_v2[`SV2_PGB];
  endsequence

  rd_answer_a: assert property (I_CMD.valid && !I_CMD.write |=> O_RD_VALID)
    else $error("read command not answered");
  ot_fault_a: assert property (ot_fault_seen |=> ot_fault_shown)
    else $error("overtemperature fault not reported");
  pg_drop_a: assert property (I_TELEM.temp > otf_r || I_OTHER_FAULT |=> !O_POWER_GOOD)
    else $error("power good kept during a fault");
  pg_low_a: assert property (I_RUN && I_TELEM.vout < pgl_r |=> O_STATUS.status_v2[`SV2_PGB])
    else $error("power good bad flag missing");
  fault_pin_a: assert property (ot_fault_seen ##0 I_CFG.fault_pin_en && I_CFG.temp_fault_mask
    |=> O_FAULT)
    else $error("fault pin not asserted");
  overtemp_warning_limit_a: assert property (I_TELEM.temp > otw_r |=> O_STATUS.status_temp[`ST_OTW])
    else $error("temperature warning flag missing");
  log_step_a: assert property (O_LOG.wr |-> O_LOG_PTR == ((O_LOG.addr == 3'h6) ? 3'h0
    : O_LOG.addr + 3'h1))
    else $error("log pointer step wrong");
  ptr_hold_a: assert property ($past(I_RST_N) && !O_LOG.wr |-> $stable(O_LOG_PTR))
    else $error("log pointer moved without an entry");
  alert_off_a: assert property (!I_CFG.alert_pin_en [*2] |-> O_ALERT_N)
    else $error("alert driven while pin not configured");
endmodule // thresh_mon_monitor

bind threshold_monitor_status thresh_mon_monitor mon_u (.*);
